// File: inc/lgpc_pkg.sv
// Contract
// - local value drives pin only in output mode
// - mode x00 func in, x10 hiz, 001/011
// - mode 101 remote value, held on loss
// - mode 111 remote value, local on loss
// - port select moves pins 1-3 to port two
// - pin two bits 7,6:4; pin one 3,2:0
// - pin six bit 7 drives in output mode
package lgpc_pkg;

   typedef logic [2:0] lgpc_mode_t;

   // register indexes; byte address is four times the index
   localparam logic [5:0] IDX_PIN_ONE_TWO = 6'h0e;
   localparam logic [5:0] IDX_PIN_THREE = 6'h0f;
   localparam logic [5:0] IDX_PIN_FIVE_SIX = 6'h10;
   localparam logic [5:0] IDX_PORT_CTRL = 6'h30;
   localparam logic [5:0] IDX_PIN_STATUS = 6'h31;

   localparam logic [7:0] RST_PIN_ONE_TWO = 8'h00;
   localparam logic [7:0] RST_PIN_THREE = 8'h00;
   localparam logic [7:0] RST_PIN_FIVE_SIX = 8'h00;
   localparam logic [7:0] RST_PORT_CTRL = 8'h00;

   // writable bits of each register
   localparam logic [7:0] MASK_PIN_ONE_TWO = 8'hff;
   localparam logic [7:0] MASK_PIN_THREE = 8'h0f;
   localparam logic [7:0] MASK_PIN_FIVE_SIX = 8'hb0;
   localparam logic [7:0] MASK_PORT_CTRL = 8'h01;

   localparam int unsigned POS_PIN_ONE_MODE = 0;
   localparam int unsigned POS_PIN_ONE_VAL = 3;
   localparam int unsigned POS_PIN_TWO_MODE = 4;
   localparam int unsigned POS_PIN_TWO_VAL = 7;
   localparam int unsigned POS_PIN_THREE_MODE = 0;
   localparam int unsigned POS_PIN_THREE_VAL = 3;
   localparam int unsigned POS_PIN_SIX_MODE = 4;
   localparam int unsigned POS_PIN_SIX_VAL = 7;
   localparam int unsigned POS_PORT_SEL = 0;

   localparam lgpc_mode_t MODE_LOCAL_OUT = 3'h1;
   localparam lgpc_mode_t MODE_LOCAL_IN = 3'h3;
   localparam lgpc_mode_t MODE_REMOTE_HOLD = 3'h5;
   localparam lgpc_mode_t MODE_REMOTE_DEFAULT = 3'h7;
   localparam logic [1:0] MODE_LOW_FUNC_IN = 2'h0;
   localparam logic [1:0] MODE_LOW_HIZ = 2'h2;
   localparam logic [1:0] MODE_SIX_OUT = 2'h1;

   // true for the three modes in which the pin is an output
   function automatic logic mode_drives(input lgpc_mode_t m);
      mode_drives = (m == MODE_LOCAL_OUT) || (m == MODE_REMOTE_HOLD) ||
                    (m == MODE_REMOTE_DEFAULT);
   endfunction : mode_drives

   function automatic logic mode_value(input lgpc_mode_t m,
                                       input logic local_value,
                                       input logic remote_value,
                                       input logic link_up);
      if (m == MODE_REMOTE_HOLD)
         mode_value = remote_value;
      else if (m == MODE_REMOTE_DEFAULT)
         mode_value = link_up ? remote_value : local_value;
      else if (m == MODE_LOCAL_OUT)
         mode_value = local_value;
      else
         mode_value = 1'b0;
   endfunction : mode_value

endpackage : lgpc_pkg

// File: hdl/lgpc_remote_hold.sv
module lgpc_remote_hold (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [2:0] remote_value,
   input wire logic link_up,
   output logic [2:0] held_value,
   output logic link_up_reg
);

   // while the link is up the value follows the far end; on loss it stays
   wire logic [2:0] held_next = link_up ? remote_value : held_value;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_value <= 3'h0;
         link_up_reg <= 1'b0;
      end else begin
         held_value <= held_next;
         link_up_reg <= link_up;
      end
   end

   a_hold_on_loss: assert property (
      @(posedge pclk) disable iff (!presetn)
      !link_up |=> held_value == $past(held_value))
      else $error("remote value changed while link lost");

endmodule : lgpc_remote_hold

// File: hdl/lgpc_pin_drive.sv
module lgpc_pin_drive (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic [2:0] mode,
   input wire logic local_value,
   input wire logic remote_value,
   input wire logic link_up,
   output logic pin_out,
   output logic pin_oe
);

   wire logic oe_next = enable & lgpc_pkg::mode_drives(mode);
   wire logic out_next = oe_next &
      lgpc_pkg::mode_value(mode, local_value, remote_value, link_up);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_oe <= 1'b0;
         pin_out <= 1'b0;
      end else begin
         pin_oe <= oe_next;
         pin_out <= out_next;
      end
   end

   a_default_on_loss: assert property (
      @(posedge pclk) disable iff (!presetn)
      enable && mode == lgpc_pkg::MODE_REMOTE_DEFAULT && !link_up
      |=> pin_oe && pin_out == $past(local_value))
      else $error("remote-default pin not at local value on link loss");

   a_remote_follow: assert property (
      @(posedge pclk) disable iff (!presetn)
      enable && mode == lgpc_pkg::MODE_REMOTE_HOLD
      |=> pin_oe && pin_out == $past(remote_value))
      else $error("remote-hold pin not carrying remote value");

endmodule : lgpc_pin_drive

// File: hdl/lgpc_top.sv
// Chosen here: the APB register port.
module lgpc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [2:0] remote_value_p0,
   input wire logic link_up_p0,
   input wire logic [2:0] remote_value_p1,
   input wire logic link_up_p1,
   input wire logic [2:0] pin_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe,
   input wire logic [2:0] second_port_pin_in,
   output logic [2:0] second_port_pin_out,
   output logic [2:0] second_port_pin_oe,
   input wire logic pin_six_in,
   output logic pin_six_out,
   output logic pin_six_oe
);

   logic [7:0] pin_one_two_reg;
   logic [7:0] pin_three_reg;
   logic [7:0] pin_five_six_reg;
   logic [7:0] port_ctrl_reg;
   logic [31:0] prdata_next;
   logic pready_next;
   logic pslverr_next;
   logic pin_six_oe_next;
   logic pin_six_out_next;

   // apb decode: one wait-free access phase after each setup
   wire logic setup_phase = psel & ~penable;
   wire logic access_done = psel & penable & pready;
   wire logic [5:0] reg_index = paddr[7:2];
   wire logic aligned = (paddr[1:0] == 2'h0);
   wire logic hit_one_two = aligned &&
      (reg_index == lgpc_pkg::IDX_PIN_ONE_TWO);
   wire logic hit_three = aligned &&
      (reg_index == lgpc_pkg::IDX_PIN_THREE);
   wire logic hit_five_six = aligned &&
      (reg_index == lgpc_pkg::IDX_PIN_FIVE_SIX);
   wire logic hit_port_ctrl = aligned &&
      (reg_index == lgpc_pkg::IDX_PORT_CTRL);
   wire logic hit_status = aligned &&
      (reg_index == lgpc_pkg::IDX_PIN_STATUS);
   wire logic hit_any = hit_one_two | hit_three | hit_five_six |
      hit_port_ctrl | hit_status;
   // status is read-only, so a write to it is refused
   wire logic access_ok = hit_any & ~(pwrite & hit_status);
   wire logic do_write = access_done & pwrite & ~pslverr;

   wire logic [7:0] wbyte = pwdata[7:0];
   wire logic [7:0] one_two_next = hit_one_two && do_write ?
      (wbyte & lgpc_pkg::MASK_PIN_ONE_TWO) : pin_one_two_reg;
   wire logic [7:0] three_next = hit_three && do_write ?
      (wbyte & lgpc_pkg::MASK_PIN_THREE) : pin_three_reg;
   wire logic [7:0] five_six_next = hit_five_six && do_write ?
      (wbyte & lgpc_pkg::MASK_PIN_FIVE_SIX) : pin_five_six_reg;
   wire logic [7:0] port_ctrl_next = hit_port_ctrl && do_write ?
      (wbyte & lgpc_pkg::MASK_PORT_CTRL) : port_ctrl_reg;

   // field extraction of the pin registers
   wire logic port_sel = port_ctrl_reg[lgpc_pkg::POS_PORT_SEL];
   wire logic [2:0] mode_one =
      pin_one_two_reg[lgpc_pkg::POS_PIN_ONE_MODE +: 3];
   wire logic [2:0] mode_two =
      pin_one_two_reg[lgpc_pkg::POS_PIN_TWO_MODE +: 3];
   wire logic [2:0] mode_three =
      pin_three_reg[lgpc_pkg::POS_PIN_THREE_MODE +: 3];
   wire logic [2:0] local_vals = {
      pin_three_reg[lgpc_pkg::POS_PIN_THREE_VAL],
      pin_one_two_reg[lgpc_pkg::POS_PIN_TWO_VAL],
      pin_one_two_reg[lgpc_pkg::POS_PIN_ONE_VAL]};
   wire logic [8:0] modes = {mode_three, mode_two, mode_one};
   wire logic [1:0] mode_six =
      pin_five_six_reg[lgpc_pkg::POS_PIN_SIX_MODE +: 2];
   wire logic val_six = pin_five_six_reg[lgpc_pkg::POS_PIN_SIX_VAL];

   // remote values, held per port across link loss
   logic [2:0] held_p0;
   logic [2:0] held_p1;
   logic link_p0_reg;
   logic link_p1_reg;

   lgpc_remote_hold u_hold_p0 (
      .pclk(pclk),
      .presetn(presetn),
      .remote_value(remote_value_p0),
      .link_up(link_up_p0),
      .held_value(held_p0),
      .link_up_reg(link_p0_reg)
   );

   lgpc_remote_hold u_hold_p1 (
      .pclk(pclk),
      .presetn(presetn),
      .remote_value(remote_value_p1),
      .link_up(link_up_p1),
      .held_value(held_p1),
      .link_up_reg(link_p1_reg)
   );

   // fields steer either the primary pins or the second port
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_pin
         lgpc_pin_drive u_primary (
            .pclk(pclk),
            .presetn(presetn),
            .enable(~port_sel),
            .mode(modes[3*g +: 3]),
            .local_value(local_vals[g]),
            .remote_value(held_p0[g]),
            .link_up(link_p0_reg),
            .pin_out(pin_out[g]),
            .pin_oe(pin_oe[g])
         );
         lgpc_pin_drive u_second (
            .pclk(pclk),
            .presetn(presetn),
            .enable(port_sel),
            .mode(modes[3*g +: 3]),
            .local_value(local_vals[g]),
            .remote_value(held_p1[g]),
            .link_up(link_p1_reg),
            .pin_out(second_port_pin_out[g]),
            .pin_oe(second_port_pin_oe[g])
         );
      end
   endgenerate

   // pin six has no remote control and is not redirected
   assign pin_six_oe_next = (mode_six == lgpc_pkg::MODE_SIX_OUT);
   assign pin_six_out_next = pin_six_oe_next & val_six;

   wire logic [2:0] sel_pin_in = port_sel ? second_port_pin_in : pin_in;
   wire logic [7:0] status_byte = {2'h0, pin_six_in, sel_pin_in,
      link_p1_reg, link_p0_reg};

   always_comb begin
      prdata_next = 32'h0;
      if (setup_phase && !pwrite && access_ok) begin
         if (hit_one_two)
            prdata_next = {24'h0, pin_one_two_reg};
         else if (hit_three)
            prdata_next = {24'h0, pin_three_reg};
         else if (hit_five_six)
            prdata_next = {24'h0, pin_five_six_reg};
         else if (hit_port_ctrl)
            prdata_next = {24'h0, port_ctrl_reg};
         else
            prdata_next = {24'h0, status_byte};
      end else if (psel && penable && !pready) begin
         prdata_next = prdata;
      end
   end

   assign pready_next = setup_phase;
   assign pslverr_next = setup_phase & ~access_ok;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_one_two_reg <= lgpc_pkg::RST_PIN_ONE_TWO;
         pin_three_reg <= lgpc_pkg::RST_PIN_THREE;
         pin_five_six_reg <= lgpc_pkg::RST_PIN_FIVE_SIX;
         port_ctrl_reg <= lgpc_pkg::RST_PORT_CTRL;
      end else begin
         pin_one_two_reg <= one_two_next;
         pin_three_reg <= three_next;
         pin_five_six_reg <= five_six_next;
         port_ctrl_reg <= port_ctrl_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_six_oe <= 1'b0;
         pin_six_out <= 1'b0;
      end else begin
         pin_six_oe <= pin_six_oe_next;
         pin_six_out <= pin_six_out_next;
      end
   end

   // checks

   sequence s_write_one_two;
      psel && penable && pready && !pslverr && pwrite && hit_one_two;
   endsequence

   sequence s_read_three_setup;
      psel && !penable && !pwrite && hit_three;
   endsequence

   sequence s_refused_access;
      psel && penable && pready && pslverr;
   endsequence

   sequence s_write_port_ctrl;
      psel && penable && pready && !pslverr && pwrite && hit_port_ctrl;
   endsequence

   a_local_drive: assert property (
      @(posedge pclk) disable iff (!presetn)
      !port_sel && mode_one == lgpc_pkg::MODE_LOCAL_OUT
      |=> pin_oe[0] && pin_out[0] == $past(local_vals[0]))
      else $error("pin one not driving local value in output mode");

   a_not_driven: assert property (
      @(posedge pclk) disable iff (!presetn)
      (mode_two[1:0] == lgpc_pkg::MODE_LOW_FUNC_IN ||
       mode_two[1:0] == lgpc_pkg::MODE_LOW_HIZ ||
       mode_two == lgpc_pkg::MODE_LOCAL_IN)
      |=> !pin_oe[1] && !second_port_pin_oe[1])
      else $error("pin two driven in a non-output mode");

   a_hold_mode: assert property (
      @(posedge pclk) disable iff (!presetn)
      !port_sel && mode_three == lgpc_pkg::MODE_REMOTE_HOLD &&
      !link_up_p0 && !link_p0_reg ##1 $stable(modes) && !port_sel
      |=> pin_oe[2] && $stable(pin_out[2]))
      else $error("remote-hold pin changed after link loss");

   a_default_mode: assert property (
      @(posedge pclk) disable iff (!presetn)
      port_sel && mode_one == lgpc_pkg::MODE_REMOTE_DEFAULT && !link_p1_reg
      |=> second_port_pin_oe[0] &&
          second_port_pin_out[0] == $past(local_vals[0]))
      else $error("second port pin one not at local value on loss");

   a_port_redirect: assert property (
      @(posedge pclk) disable iff (!presetn)
      port_sel |=> pin_oe == 3'h0)
      else $error("primary pins driven while second port selected");

   a_field_layout: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_write_one_two ##1 (pin_one_two_reg[6:4] == lgpc_pkg::MODE_LOCAL_OUT
      && !port_sel)
      |=> pin_oe[1] && pin_out[1] == $past(pwdata[7], 2))
      else $error("pin two fields not at bits 7 and 6:4");

   a_pin_six: assert property (
      @(posedge pclk) disable iff (!presetn)
      mode_six == lgpc_pkg::MODE_SIX_OUT
      |=> pin_six_oe && pin_six_out == $past(val_six))
      else $error("pin six not driving its output value");

   a_pin_six_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      mode_six != lgpc_pkg::MODE_SIX_OUT |=> !pin_six_oe && !pin_six_out)
      else $error("pin six driven outside output mode");

   a_reserved_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_read_three_setup |=> pready && prdata[31:4] == 28'h0)
      else $error("reserved bits of pin three read nonzero");

   a_reserved_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      1'b1 |-> pin_three_reg[7:4] == 4'h0 && pin_five_six_reg[6] == 1'b0 &&
      pin_five_six_reg[3:0] == 4'h0)
      else $error("reserved bits took a written value");

   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready)
      else $error("apb access phase not exactly one cycle");

   a_second_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      port_sel && mode_three == lgpc_pkg::MODE_REMOTE_HOLD
      |=> second_port_pin_oe[2] &&
          second_port_pin_out[2] == $past(held_p1[2]))
      else $error("second port pin three not carrying held value");

   a_second_follow: assert property (
      @(posedge pclk) disable iff (!presetn)
      port_sel && mode_one == lgpc_pkg::MODE_REMOTE_DEFAULT && link_p1_reg
      |=> second_port_pin_out[0] == $past(held_p1[0]))
      else $error("second port pin one not carrying remote value");

   a_second_idle: assert property (
      @(posedge pclk) disable iff (!presetn)
      !port_sel |=> second_port_pin_oe == 3'h0)
      else $error("second port pins driven while primary selected");

   a_port_select: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_write_port_ctrl |=> port_sel == $past(pwdata[lgpc_pkg::POS_PORT_SEL]))
      else $error("port select not taken from write data");

   a_write_lands: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_write_one_two |=> pin_one_two_reg == $past(pwdata[7:0]))
      else $error("pin one and two register not taking write data");

   a_refused_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_refused_access |=> $stable(pin_one_two_reg) && $stable(pin_three_reg)
      && $stable(pin_five_six_reg) && $stable(port_ctrl_reg))
      else $error("refused access changed a register");

   a_prdata_idle: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready |-> prdata[31:8] == 24'h0 ##1 prdata == 32'h0)
      else $error("read data not zero outside its access cycle");

   a_unaligned_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !aligned |=> pready && pslverr)
      else $error("unaligned access not refused");

endmodule : lgpc_top

// File: test/lgpc_remote_model.sv
module lgpc_remote_model (
   input wire logic pclk,
   output logic [2:0] remote_value_p0,
   output logic link_up_p0,
   output logic [2:0] remote_value_p1,
   output logic link_up_p1
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] v0 = 3'h0;
   logic [2:0] v1 = 3'h0;
   logic u0 = 1'b0;
   logic u1 = 1'b0;
   initial begin
      remote_value_p0 = 3'h0;
      remote_value_p1 = 3'h0;
      link_up_p0 = 1'b0;
      link_up_p1 = 1'b0;
   end
   task automatic set(input int p, input logic up, input logic [2:0] v);
      if (p == 0) begin
         u0 <= up;
         v0 <= v;
      end else begin
         u1 <= up;
         v1 <= v;
      end
   endtask : set
   // a lost link carries no valid value, so it changes every cycle
   always @(posedge pclk) begin
      link_up_p0 <= u0;
      link_up_p1 <= u1;
      remote_value_p0 <= u0 ? v0 : ~remote_value_p0;
      remote_value_p1 <= u1 ? v1 : ~remote_value_p1;
   end
endmodule : lgpc_remote_model

// File: test/lgpc_top_tb.sv
module lgpc_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] rv0, rv1, pin_out, pin_oe, sp_out, sp_oe;
   logic lu0, lu1, six_out, six_oe;
   logic [2:0] pin_in = 3'h2;
   logic [2:0] sp_in = 3'h5;
   logic six_in = 1'b1;
   int error_cnt = 0;
   int checks_done = 0;

   always #2.5 pclk = ~pclk;

   lgpc_remote_model i_far (.pclk(pclk), .remote_value_p0(rv0),
      .link_up_p0(lu0), .remote_value_p1(rv1), .link_up_p1(lu1));

   lgpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .remote_value_p0(rv0), .link_up_p0(lu0), .remote_value_p1(rv1),
      .link_up_p1(lu1), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .second_port_pin_in(sp_in),
      .second_port_pin_out(sp_out), .second_port_pin_oe(sp_oe),
      .pin_six_in(six_in), .pin_six_out(six_out), .pin_six_oe(six_oe));

   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] rd,
                      output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic err_exp);
      logic [7:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk("write error", {31'h0, e}, {31'h0, err_exp});
   endtask : wr

   task automatic rd(input string name, input logic [7:0] a,
                     input logic [7:0] exp, input logic err_exp);
      logic [7:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      chk(name, {24'h0, r}, {24'h0, exp});
      chk("read error", {31'h0, e}, {31'h0, err_exp});
   endtask : rd

   // give remote and register changes time to reach the pins
   task automatic pins(input logic [2:0] oe, input logic [2:0] out,
                       input logic [2:0] oe2, input logic [2:0] out2);
      repeat (5) @(posedge pclk);
      #1;
      chk("pin_oe", {29'h0, pin_oe}, {29'h0, oe});
      chk("pin_out", {29'h0, pin_out}, {29'h0, out});
      chk("second_port_pin_oe", {29'h0, sp_oe}, {29'h0, oe2});
      chk("second_port_pin_out", {29'h0, sp_out}, {29'h0, out2});
   endtask : pins

   task automatic test_reset_and_fields;
      rd("pin_one_two_config", 8'h38, 8'h00, 1'b0);
      rd("pin_three_config", 8'h3c, 8'h00, 1'b0);
      rd("pin_five_six_config", 8'h40, 8'h00, 1'b0);
      chk("pin_six_oe", {31'h0, six_oe}, 32'h0);
      wr(8'h38, 8'hff, 1'b0);
      rd("pin_one_two_config", 8'h38, 8'hff, 1'b0);
      wr(8'h3c, 8'hff, 1'b0);
      rd("pin_three_config", 8'h3c, 8'h0f, 1'b0);
      wr(8'h40, 8'h4f, 1'b0);
      rd("pin_five_six_config", 8'h40, 8'h00, 1'b0);
      rd("unmapped", 8'h80, 8'h00, 1'b1);
      wr(8'h39, 8'h00, 1'b1);
   endtask : test_reset_and_fields

   // locals 1,0,1 against remote 0,1,0 tell both sources apart
   task automatic test_modes;
      logic [2:0] oe, out;
      i_far.set(0, 1'b1, 3'h2);
      for (int m = 0; m < 8; m++) begin
         wr(8'h38, {1'b0, m[2:0], 1'b1, m[2:0]}, 1'b0);
         wr(8'h3c, {5'h01, m[2:0]}, 1'b0);
         oe = (m == 1 || m == 5 || m == 7) ? 3'h7 : 3'h0;
         out = (m == 1) ? 3'h5 : (m == 5 || m == 7) ? 3'h2 : 3'h0;
         pins(oe, out, 3'h0, 3'h0);
      end
   endtask : test_modes

   task automatic test_link_loss;
      wr(8'h38, 8'hf5, 1'b0);
      wr(8'h3c, 8'h0d, 1'b0);
      i_far.set(0, 1'b1, 3'h1);
      pins(3'h7, 3'h1, 3'h0, 3'h0);
      i_far.set(0, 1'b0, 3'h1);
      pins(3'h7, 3'h3, 3'h0, 3'h0);
      i_far.set(0, 1'b1, 3'h6);
      pins(3'h7, 3'h6, 3'h0, 3'h0);
   endtask : test_link_loss

   task automatic test_port_select;
      i_far.set(1, 1'b1, 3'h4);
      wr(8'hc0, 8'h01, 1'b0);
      wr(8'h40, 8'h90, 1'b0);
      pins(3'h0, 3'h0, 3'h7, 3'h4);
      chk("pin_six_out", {30'h0, six_oe, six_out}, 32'h3);
      rd("status", 8'hc4, 8'h37, 1'b0);
      wr(8'hc4, 8'h00, 1'b1);
      wr(8'h38, 8'hff, 1'b0);
      i_far.set(1, 1'b0, 3'h4);
      pins(3'h0, 3'h0, 3'h7, 3'h7);
      wr(8'hc0, 8'h00, 1'b0);
      rd("status", 8'hc4, 8'h29, 1'b0);
      wr(8'h40, 8'ha0, 1'b0);
      pins(3'h7, 3'h6, 3'h0, 3'h0);
      chk("pin_six_out", {30'h0, six_oe, six_out}, 32'h0);
      wr(8'h40, 8'h10, 1'b0);
      pins(3'h7, 3'h6, 3'h0, 3'h0);
      chk("pin_six_out", {30'h0, six_oe, six_out}, 32'h2);
   endtask : test_port_select

   task automatic results;
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results

   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      results();
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      test_reset_and_fields();
      test_modes();
      test_link_loss();
      test_port_select();
      results();
   end
endmodule : lgpc_top_tb
